//--- logic/qsr_core.sv
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "qsr_consts.svh"


module qsr_core #(
  parameter int unsigned SR_LEN = `QSR_LEN_SHORT
) (
  // Clock and reset
  input  wire logic                   MCLK_I,
  input  wire logic                   RESET_I,
  // Line pins
  input  wire logic                   SHIFT_CLK_I,
  input  wire logic                   SERIAL_IN_A_I,
  input  wire logic                   SERIAL_IN_B_I,
  input  wire logic                   SERIAL_IN_C_I,
  input  wire logic                   SERIAL_IN_REG4_I,
  input  wire logic                   RECIRC_IN_REG4_I,
  input  wire logic                   RECIRC_SEL_ABC_I,
  input  wire logic                   RECIRC_SEL_REG4_I,
  input  wire logic                   SHIFT_LEFT_I,
  input  wire logic                   CLEAR_ALL_I,
  output logic                        SERIAL_OUT_A_O,
  output logic                        SERIAL_OUT_B_O,
  output logic                        SERIAL_OUT_C_O,
  output logic                        SERIAL_OUT_REG4_O,
  // APB slave
  input  wire logic                   PSEL_I,
  input  wire logic                   PENABLE_I,
  input  wire logic                   PWRITE_I,
  input  wire logic [`QSR_ADDR_W-1:0] PADDR_I,
  input  wire logic [`QSR_DATA_W-1:0] PWDATA_I,
  output logic      [`QSR_DATA_W-1:0] PRDATA_O,
  output logic                        PREADY_O,
  output logic                        PSLVERR_O
);

  localparam int unsigned NREG = `QSR_REGS;

  qsr_pkg::qsr_pins_t        pin_raw_w;
  qsr_pkg::qsr_pins_t        pin_s1_r;
  qsr_pkg::qsr_pins_t        pin_s2_r;
  qsr_pkg::qsr_pins_t        held_r;
  qsr_pkg::qsr_pins_t        cur_w;
  logic                      sclk_s3_r;
  logic                      edge_w;
  logic                      dir_left_w;
  logic                      clr_w;
  logic                      req_w;
  logic                      room_w;
  logic                      step_w;
  logic                      pend_r;
  logic                      pend_nxt;
  logic                      ovr_r;
  logic                      ovr_nxt;
  logic                      cap_en_r;
  logic [`QSR_CNT_W-1:0]     cnt_r;
  logic [NREG-1:0]           falls_w;
  logic [NREG-1:0]           outs_w;
  logic [NREG-1:0]           flags_w;
  logic                      buf_in_ready_w;
  logic                      buf_out_valid_w;
  logic [`QSR_WORD_W-1:0]    buf_out_data_w;
  logic                      pop_w;
  logic                      setup_w;
  logic                      done_w;
  logic                      wr_done_w;
  logic                      rd_done_w;
  logic                      hit_ctrl_w;
  logic                      hit_stat_w;
  logic                      hit_word_w;
  logic                      hit_cnt_w;
  logic                      mapped_w;
  logic                      sw_step_w;
  logic                      sw_clr_w;
  logic                      ovr_clr_w;
  logic [`QSR_DATA_W-1:0]    rdata_w;
  logic [`QSR_DATA_W-1:0]    prdata_r;
  logic                      pready_r;
  logic                      pslverr_r;

  function automatic logic [SR_LEN-1:0] qsr_shift(
    input logic [SR_LEN-1:0] v,
    input logic              b,
    input logic              left
  );
    qsr_shift = left ? {b, v[SR_LEN-1:1]} : {v[SR_LEN-2:0], b};
  endfunction

  function automatic logic qsr_fall(
    input logic [SR_LEN-1:0] v,
    input logic              left
  );
    qsr_fall = left ? v[0] : v[SR_LEN-1];
  endfunction

  // Pin synchroniser; edge found between second and third stage
  assign pin_raw_w = '{
    ser_in:          {SERIAL_IN_REG4_I, SERIAL_IN_C_I,
                      SERIAL_IN_B_I, SERIAL_IN_A_I},
    recirc_in_reg4:  RECIRC_IN_REG4_I,
    recirc_sel_abc:  RECIRC_SEL_ABC_I,
    recirc_sel_reg4: RECIRC_SEL_REG4_I,
    dir:             qsr_pkg::qsr_dir_t'(SHIFT_LEFT_I),
    clear_all:       CLEAR_ALL_I,
    sclk:            SHIFT_CLK_I
  };

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pin_s1_r  <= '0;
      pin_s2_r  <= '0;
      sclk_s3_r <= 1'b0;
    end else begin
      pin_s1_r  <= pin_raw_w;
      pin_s2_r  <= pin_s1_r;
      sclk_s3_r <= pin_s2_r.sclk;
    end
  end

  // Step control
  assign edge_w     = pin_s2_r.sclk & ~sclk_s3_r;
  // Waiting step keeps the pins seen at its edge
  assign cur_w      = pend_r ? held_r : pin_s2_r;
  assign dir_left_w = (cur_w.dir == qsr_pkg::QSR_LEFT);
  assign clr_w      = pin_s2_r.clear_all | sw_clr_w;
  assign req_w      = edge_w | sw_step_w | pend_r;
  assign room_w     = ~cap_en_r | buf_in_ready_w;
  assign step_w     = req_w & room_w & ~clr_w;
  assign pend_nxt   = req_w & ~step_w & ~clr_w;
  // Lost step when a new one meets a waiting one; set beats clear
  assign ovr_nxt    = ((edge_w | sw_step_w) & pend_r) | (ovr_r & ~ovr_clr_w);

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pend_r <= 1'b0;
      ovr_r  <= 1'b0;
      held_r <= '0;
    end else begin
      pend_r <= pend_nxt;
      ovr_r  <= ovr_nxt;
      held_r <= cur_w;
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cnt_r <= '0;
    end else if (clr_w) begin
      cnt_r <= '0;
    end else if (step_w) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Four independent registers, each SR_LEN bits
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    logic [SR_LEN-1:0] sr_r;
    logic [SR_LEN-1:0] sr_nxt;
    logic              out_r;
    logic              src_w;

    assign falls_w[g] = qsr_fall(sr_r, dir_left_w);
    if (g == NREG - 1) begin : g_last
      assign src_w = cur_w.recirc_sel_reg4
                   ? cur_w.recirc_in_reg4 : cur_w.ser_in[g];
    end else begin : g_abc
      assign src_w = cur_w.recirc_sel_abc
                   ? falls_w[g] : cur_w.ser_in[g];
    end
    assign sr_nxt     = qsr_shift(sr_r, src_w, dir_left_w);
    assign outs_w[g]  = out_r;
    assign flags_w[g] = sr_r[SR_LEN-1];

    // Holds whenever neither a step nor a clear is taken
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
        sr_r  <= '0;
        out_r <= 1'b0;
      end else if (clr_w) begin
        sr_r  <= '0;
        out_r <= 1'b0;
      end else if (step_w) begin
        sr_r  <= sr_nxt;
        out_r <= falls_w[g];
      end
    end
  end

  assign SERIAL_OUT_A_O    = outs_w[0];
  assign SERIAL_OUT_B_O    = outs_w[1];
  assign SERIAL_OUT_C_O    = outs_w[2];
  assign SERIAL_OUT_REG4_O = outs_w[3];

  // Each step's outgoing bits while capture is enabled, read back by software
  qsr_buf #(
    .WIDTH (`QSR_WORD_W),
    .DEPTH (`QSR_BUF_DEPTH)
  ) u_buf (
    .clk_i       (MCLK_I),
    .rst_i       (RESET_I),
    .in_valid_i  (step_w & cap_en_r),
    .in_ready_o  (buf_in_ready_w),
    .in_data_i   (falls_w),
    .out_valid_o (buf_out_valid_w),
    .out_ready_i (pop_w),
    .out_data_o  (buf_out_data_w)
  );

  // APB decode
  assign setup_w    = PSEL_I & ~PENABLE_I;
  assign done_w     = PSEL_I & PENABLE_I & pready_r;
  assign wr_done_w  = done_w & PWRITE_I;
  assign rd_done_w  = done_w & ~PWRITE_I;
  assign hit_ctrl_w = (PADDR_I == `QSR_OFF_CTRL);
  assign hit_stat_w = (PADDR_I == `QSR_OFF_STAT);
  assign hit_word_w = (PADDR_I == `QSR_OFF_WORD);
  assign hit_cnt_w  = (PADDR_I == `QSR_OFF_CNT);
  assign mapped_w   = hit_ctrl_w | hit_stat_w | hit_word_w | hit_cnt_w;
  assign sw_step_w  = wr_done_w & hit_ctrl_w & PWDATA_I[`QSR_CTRL_STEP];
  assign sw_clr_w   = wr_done_w & hit_ctrl_w & PWDATA_I[`QSR_CTRL_CLEAR];
  assign ovr_clr_w  = wr_done_w & hit_stat_w & PWDATA_I[`QSR_STAT_OVR];
  // Pop only what the setup cycle showed as valid
  assign pop_w      = rd_done_w & hit_word_w & prdata_r[`QSR_WORD_VLD];

  always_comb begin
    rdata_w = '0;
    if (hit_ctrl_w) begin
      rdata_w[`QSR_CTRL_CAPEN] = cap_en_r;
    end else if (hit_stat_w) begin
      rdata_w[NREG-1:0]         = flags_w;
      rdata_w[`QSR_STAT_PEND]   = pend_r;
      rdata_w[`QSR_STAT_OVR]    = ovr_r;
      rdata_w[`QSR_STAT_AVAIL]  = buf_out_valid_w;
    end else if (hit_word_w) begin
      rdata_w[`QSR_WORD_W-1:0]  = buf_out_valid_w ? buf_out_data_w : '0;
      rdata_w[`QSR_WORD_VLD]    = buf_out_valid_w;
    end else if (hit_cnt_w) begin
      rdata_w[`QSR_CNT_W-1:0]   = cnt_r;
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cap_en_r <= `QSR_CAPEN_RST;
    end else if (wr_done_w && hit_ctrl_w) begin
      cap_en_r <= PWDATA_I[`QSR_CTRL_CAPEN];
    end
  end

  // No wait state: answer prepared in the setup cycle
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (setup_w) begin
      prdata_r  <= rdata_w;
      pready_r  <= 1'b1;
      pslverr_r <= ~mapped_w;
    end else if (done_w) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign PRDATA_O  = prdata_r;
  assign PREADY_O  = pready_r;
  assign PSLVERR_O = pslverr_r;

  // Checks
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RESET_I);

  sequence s_step_right;
    step_w && !dir_left_w;
  endsequence

  sequence s_step_left;
    step_w && dir_left_w;
  endsequence

  a_load_input_a: assert property (
    s_step_right ##0 !cur_w.recirc_sel_abc
    |=> g_reg[0].sr_r[0] == $past(cur_w.ser_in[0]))
    else $error("register A did not load its input");

  a_out_on_step: assert property (
    s_step_right |=> SERIAL_OUT_B_O == $past(g_reg[1].sr_r[SR_LEN-1]))
    else $error("output B not the bit shifted out");

  a_hold_idle: assert property (
    !step_w && !clr_w |=> $stable(g_reg[2].sr_r) && $stable(outs_w))
    else $error("contents changed without a step");

  a_recirc_abc: assert property (
    s_step_right ##0 cur_w.recirc_sel_abc
    |=> g_reg[1].sr_r[0] == $past(g_reg[1].sr_r[SR_LEN-1]))
    else $error("register B did not recirculate");

  a_reg4_free: assert property (
    s_step_right ##0 (cur_w.recirc_sel_abc && !cur_w.recirc_sel_reg4)
    |=> g_reg[3].sr_r[0] == $past(cur_w.ser_in[3]))
    else $error("register D followed the common select");

  a_reg4_recirc: assert property (
    s_step_right ##0 cur_w.recirc_sel_reg4
    |=> g_reg[3].sr_r[0] == $past(cur_w.recirc_in_reg4))
    else $error("register D ignored its recirculate input");

  a_clear_all: assert property (
    $rose(CLEAR_ALL_I) |-> ##[1:3] (outs_w == '0 && g_reg[0].sr_r == '0))
    else $error("clear did not empty the registers");

  a_move_right: assert property (
    s_step_right
    |=> g_reg[2].sr_r[SR_LEN-1:1] == $past(g_reg[2].sr_r[SR_LEN-2:0]))
    else $error("right shift moved bits wrongly");

  a_move_left: assert property (
    s_step_left ##0 !cur_w.recirc_sel_abc
    |=> g_reg[2].sr_r == {$past(cur_w.ser_in[2]),
                          $past(g_reg[2].sr_r[SR_LEN-1:1])})
    else $error("left shift moved bits wrongly");

  a_flag_read: assert property (
    rd_done_w && hit_stat_w |-> PRDATA_O[NREG-1:0] == $past(flags_w))
    else $error("status did not show the final bits");

  a_stall_full: assert property (
    req_w && cap_en_r && !buf_in_ready_w && !clr_w
    |=> pend_r && $stable(g_reg[0].sr_r))
    else $error("step taken while the buffer was full");

endmodule // qsr_core

`default_nettype wire

//--- logic/qsr_consts.svh
`ifndef QSR_CONSTS_SVH
`define QSR_CONSTS_SVH

// Register length choices (81 and 133)
`define QSR_LEN_SHORT  8'h51
`define QSR_LEN_LONG   8'h85
`define QSR_REGS       4'h4

// Output word buffer
`define QSR_WORD_W     4'h4
`define QSR_BUF_DEPTH  4'h2

// Bus shape
`define QSR_ADDR_W     4'h8
`define QSR_DATA_W     8'h20

// Register byte offsets
`define QSR_OFF_CTRL   8'h00
`define QSR_OFF_STAT   8'h04
`define QSR_OFF_WORD   8'h08
`define QSR_OFF_CNT    8'h0c

// Field positions and the count field width
`define QSR_CTRL_STEP  5'h00
`define QSR_CTRL_CLEAR 5'h01
`define QSR_CTRL_CAPEN 5'h02
`define QSR_STAT_PEND  5'h04
`define QSR_STAT_OVR   5'h05
`define QSR_STAT_AVAIL 5'h06
`define QSR_WORD_VLD   5'h04
`define QSR_CNT_W      8'h10

// Reset values
`define QSR_CAPEN_RST  1'h0

`endif

//--- logic/qsr_pkg.sv
`default_nettype none
`include "qsr_consts.svh"

package qsr_pkg;

  typedef enum logic {
    QSR_RIGHT = 1'b0,
    QSR_LEFT  = 1'b1
  } qsr_dir_t;

  // Pin group, sampled together
  typedef struct packed {
    logic [`QSR_REGS-1:0] ser_in;
    logic                 recirc_in_reg4;
    logic                 recirc_sel_abc;
    logic                 recirc_sel_reg4;
    qsr_dir_t             dir;
    logic                 clear_all;
    logic                 sclk;
  } qsr_pins_t;

endpackage

`default_nettype wire

//--- logic/qsr_buf.sv
`timescale 1ns/10ps
`default_nettype none
`include "qsr_consts.svh"

module qsr_buf #(
  parameter int unsigned WIDTH = `QSR_WORD_W,
  parameter int unsigned DEPTH = `QSR_BUF_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  logic             push_w;
  logic             pop_w;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push_w      = in_valid_i & in_ready_o;
  assign pop_w       = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push_w) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push_w) begin
        wr_ptr_r <= next_ptr(wr_ptr_r);
      end
      if (pop_w) begin
        rd_ptr_r <= next_ptr(rd_ptr_r);
      end
      if (push_w && !pop_w) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop_w && !push_w) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule // qsr_buf

`default_nettype wire

//--- sim/qsr_line_ctl.sv
`timescale 1ns/10ps
`default_nettype none

module qsr_line_ctl (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Step request
  input  wire logic               step_i,
  input  wire qsr_pkg::qsr_pins_t pins_i,
  // Line pins and busy flag
  output var qsr_pkg::qsr_pins_t  pins_o,
  output var logic                busy_o
);
  qsr_pkg::qsr_pins_t t;

  // Data and selects held for the whole step, clock low while idle
  initial begin
    pins_o = '0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      t = pins_i;
      t.sclk = 1'b0;
      if (rst_i) begin
        pins_o <= '0;
      end else if (!busy_o) begin
        pins_o <= t;
        if (step_i) begin
          busy_o <= 1'b1;
          repeat (25) @(posedge clk_i);
          pins_o.sclk <= 1'b1;
          repeat (75) @(posedge clk_i);
          pins_o.sclk <= 1'b0;
          repeat (150) @(posedge clk_i);
          busy_o <= 1'b0;
        end
      end
    end
  end
endmodule // qsr_line_ctl

`default_nettype wire

//--- sim/quad_bidir_recirc_shift_register_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "qsr_consts.svh"

`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("[FAIL] %s exp %h got %h", nm, (e), (g)); \
  end \
end

module quad_bidir_recirc_shift_register_bench;
  localparam int LEN = `QSR_LEN_SHORT;
  logic               clk, rst, step, psel, pen, pwr, pready, pslverr, busy;
  logic               err;
  logic [3:0]         exp_o;
  logic [4:0]         ew;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  wire  [3:0]         sout;
  qsr_pkg::qsr_pins_t pins, pp, pr;
  qsr_pkg::qsr_pins_t pv [4];
  logic [LEN-1:0]     m [4];
  logic [3:0]         wq [$];
  int                 error_cnt, n_compared, m_cnt, seed;

  qsr_line_ctl u_qsr_line_ctl (
    .clk_i (clk), .rst_i (rst), .step_i (step), .pins_i (pins),
    .pins_o (pp), .busy_o (busy)
  );

  qsr_core #(.SR_LEN(LEN)) u_qsr_core (
    .MCLK_I            (clk),
    .RESET_I           (rst),
    .SHIFT_CLK_I       (pp.sclk),
    .SERIAL_IN_A_I     (pp.ser_in[0]),
    .SERIAL_IN_B_I     (pp.ser_in[1]),
    .SERIAL_IN_C_I     (pp.ser_in[2]),
    .SERIAL_IN_REG4_I  (pp.ser_in[3]),
    .RECIRC_IN_REG4_I  (pp.recirc_in_reg4),
    .RECIRC_SEL_ABC_I  (pp.recirc_sel_abc),
    .RECIRC_SEL_REG4_I (pp.recirc_sel_reg4),
    .SHIFT_LEFT_I      (pp.dir),
    .CLEAR_ALL_I       (pp.clear_all),
    .SERIAL_OUT_A_O    (sout[0]),
    .SERIAL_OUT_B_O    (sout[1]),
    .SERIAL_OUT_C_O    (sout[2]),
    .SERIAL_OUT_REG4_O (sout[3]),
    .PSEL_I            (psel),
    .PENABLE_I         (pen),
    .PWRITE_I          (pwr),
    .PADDR_I           (paddr),
    .PWDATA_I          (pwdata),
    .PRDATA_O          (prdata),
    .PREADY_O          (pready),
    .PSLVERR_O         (pslverr)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic void mclr();
    foreach (m[r]) m[r] = '0;
    m_cnt = 0;
  endfunction

  // Reference step: returns the bits leaving {D,C,B,A}
  function automatic logic [3:0] mstep(qsr_pkg::qsr_pins_t p);
    logic [3:0] o;
    logic       b;
    for (int r = 0; r < 4; r++) begin
      o[r] = (p.dir == qsr_pkg::QSR_LEFT) ? m[r][0] : m[r][LEN-1];
      b = p.ser_in[r];
      if (r < 3 && p.recirc_sel_abc) b = o[r];
      if (r == 3 && p.recirc_sel_reg4) b = p.recirc_in_reg4;
      if (p.dir == qsr_pkg::QSR_LEFT) m[r] = {b, m[r][LEN-1:1]};
      else m[r] = {m[r][LEN-2:0], b};
    end
    m_cnt++;
    return o;
  endfunction

  function automatic qsr_pkg::qsr_pins_t rnd();
    qsr_pkg::qsr_pins_t p;
    p = qsr_pkg::qsr_pins_t'(10'($random(seed)));
    p.clear_all = 1'b0;
    p.sclk = 1'b0;
    return p;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic do_step(input qsr_pkg::qsr_pins_t p);
    @(posedge clk);
    pins <= p;
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    do @(posedge clk);
    while (busy !== 1'b0);
  endtask

  task automatic pin_clear();
    @(posedge clk);
    pins.clear_all <= 1'b1;
    repeat (25) @(posedge clk);
    `CHK("cleared", 4'h0, sout)
    pins.clear_all <= 1'b0;
    repeat (8) @(posedge clk);
    mclr();
  endtask

  task automatic chk_stat();
    logic [3:0] fb;
    for (int r = 0; r < 4; r++) fb[r] = m[r][LEN-1];
    apb(1'b0, `QSR_OFF_STAT, 32'h0);
    `CHK("final bits", fb, rd[3:0])
    apb(1'b0, `QSR_OFF_CNT, 32'h0);
    `CHK("step count", {16'h0, m_cnt[15:0]}, rd)
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    seed = 32'h4df6;
    rst = 1'b1;
    step = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = '0;
    pwdata = '0;
    pins = '0;
    error_cnt = 0;
    n_compared = 0;
    mclr();
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("reset outputs", 4'h0, sout)
    apb(1'b0, `QSR_OFF_CTRL, 32'h0);
    `CHK("capen reset", `QSR_CAPEN_RST, rd[2])
    for (int i = 0; i < 180; i++) begin
      if ($random(seed) % 24 == 0) pin_clear();
      pr = rnd();
      exp_o = mstep(pr);
      do_step(pr);
      `CHK("outputs", exp_o, sout)
      if (i % 45 == 44) chk_stat();
    end
    repeat (300) @(posedge clk);
    `CHK("held", exp_o, sout)
    // Two words fill the buffer, the third step waits, the fourth is lost
    apb(1'b1, `QSR_OFF_CTRL, 32'h4);
    for (int i = 0; i < 4; i++) begin
      pv[i] = rnd();
      if (i < 2) begin
        exp_o = mstep(pv[i]);
        wq.push_back(exp_o);
      end
      do_step(pv[i]);
      `CHK("stall outputs", exp_o, sout)
    end
    apb(1'b0, `QSR_OFF_STAT, 32'h0);
    `CHK("pend ovr avail", 3'h7, rd[6:4])
    apb(1'b1, `QSR_OFF_STAT, 32'h20);
    apb(1'b0, `QSR_OFF_STAT, 32'h0);
    `CHK("ovr cleared", 3'h5, rd[6:4])
    exp_o = mstep(pv[2]);
    wq.push_back(exp_o);
    repeat (4) begin
      apb(1'b0, `QSR_OFF_WORD, 32'h0);
      ew = (wq.size() > 0) ? {1'b1, wq.pop_front()} : 5'h00;
      `CHK("word", ew, rd[4:0])
    end
    `CHK("late step", exp_o, sout)
    apb(1'b0, `QSR_OFF_STAT, 32'h0);
    `CHK("drained", 3'h0, rd[6:4])
    apb(1'b1, `QSR_OFF_CTRL, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b1, `QSR_OFF_CTRL, 32'h2);
    repeat (8) @(posedge clk);
    mclr();
    `CHK("soft clear", 4'h0, sout)
    chk_stat();
    apb(1'b1, `QSR_OFF_CTRL, 32'h1);
    exp_o = mstep(pins);
    repeat (2) @(posedge clk);
    `CHK("soft step", exp_o, sout)
    chk_stat();
    wrap_up();
  end
endmodule // quad_bidir_recirc_shift_register_bench

`default_nettype wire
